//--- logic/chc_ctrl.sv
// Hold/restart control, parameter slots, reference and aux selection,
// and storage access for a frequency counter, as an APB slave.
// Assumes measurement core signals are on pclk; pins are asynchronous.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
module chc_ctrl
  import chc_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurement core
  input  wire logic        meas_done,
  input  wire logic [31:0] meas_value,
  input  wire logic        stat_done,
  input  wire logic        judge_valid,
  input  wire logic        judge_pass,
  input  wire logic        gate_open,
  input  wire logic        burst_det,
  input  wire logic        acq_busy,
  input  wire logic        fast_valid,
  input  wire logic [31:0] fast_interval,
  input  wire logic [31:0] fast_ref,
  input  wire logic        setup_screen,
  output logic             meas_enable,
  output logic             meas_restart,
  output logic             stat_clear,
  // Pins
  input  wire logic        ext_ref_present,
  input  wire logic [1:0]  ext_ref_code,
  input  wire logic        init_key,
  output logic             hold_led,
  output logic             ref_sel_ext,
  output logic      [1:0]  ref_freq,
  output logic             aux_out,
  output logic      [2:0]  lcd_level,
  output logic      [4:0]  gpib_addr
);
  chc_hold_e        state;
  chc_hold_e        next_state;
  logic [CFG_W-1:0] cfg;
  logic [CFG_W-1:0] slot_mem [SLOTS];
  logic [SLOTS-1:0] slot_valid;
  logic [31:0]      disp_value;
  logic [31:0]      fast_m;
  logic [31:0]      fast_t;
  logic [31:0]      offset_freq;
  logic [6:0]       store_idx;
  logic             judge_q;
  logic             store_err;
  logic [1:0]       init_cnt;
  logic [3:0]       pin_s1;
  logic [3:0]       pin_s2;
  logic             wr;
  logic             rd_setup;
  logic             hold_cmd;
  logic             restart_cmd;
  logic             preset_cmd;
  logic             param_chg;
  logic             recall_ok;
  logic             end_n;
  logic             rest_n;
  logic             next_aux;
  logic             mapped;
  logic [31:0]      next_rdata;
  logic [3:0]       slot_no;
  chc_store_if      sif ();

  // Field helpers
  function automatic logic [2:0] aux_sel(input logic [CFG_W-1:0] c);
    return c[CFG_AUX_LSB +: 3];
  endfunction
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // APB strobes; zero wait states keep the master simple
  assign pready      = 1'b1;
  assign wr          = psel && penable && pwrite;
  assign rd_setup    = psel && !penable && !pwrite;
  assign hold_cmd    = wr && hit(paddr, OFF_CTRL) && pwdata[CTL_HOLD];
  assign restart_cmd = wr && hit(paddr, OFF_CTRL) && pwdata[CTL_RESTART];
  assign preset_cmd  = wr && hit(paddr, OFF_CTRL) && pwdata[CTL_PRESET];
  assign slot_no     = pwdata[3:0];
  assign recall_ok   = wr && hit(paddr, OFF_SLOT) && pwdata[SLOT_RECALL]
                       && slot_no < 4'(SLOTS) && slot_valid[slot_no];
  assign param_chg   = (wr && hit(paddr, OFF_CFG)) || preset_cmd || recall_ok;
  assign mapped      = hit(paddr, OFF_CTRL) || hit(paddr, OFF_CFG)
                       || hit(paddr, OFF_STATUS) || hit(paddr, OFF_GPIB)
                       || hit(paddr, OFF_SLOT) || hit(paddr, OFF_STORE_IDX)
                       || hit(paddr, OFF_STORE_DAT) || hit(paddr, OFF_FAST_M)
                       || hit(paddr, OFF_FAST_T) || hit(paddr, OFF_OFFSET)
                       || hit(paddr, OFF_DISP);
  assign pslverr     = psel && penable && !mapped;

  // Pin synchronisers: only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= {init_key, ext_ref_code, ext_ref_present};
      pin_s2 <= pin_s1;
    end
  end

  // Hold state machine
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (hold_cmd) next_state = ST_HELD;
      end
      ST_HELD: begin
        if (hold_cmd) next_state = ST_RUN;
        // single shot on restart or change
        else if (restart_cmd || param_chg) next_state = ST_SINGLE;
      end
      ST_SINGLE: begin
        if (hold_cmd) next_state = ST_RUN;
        else if (cfg[CFG_STAT] && stat_done) next_state = ST_HELD;
        // back to hold after one measurement
        else if (!cfg[CFG_STAT] && meas_done) next_state = ST_HELD;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= ST_RUN;
    else state <= next_state;
  end

  // measuring stops while held, indicator lit
  assign meas_enable = (state != ST_HELD);
  assign hold_led    = (state != ST_RUN);

  // restart pulses and sample counter clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_restart <= 1'b0;
      stat_clear   <= 1'b0;
    end else begin
      meas_restart <= restart_cmd;
      stat_clear   <= restart_cmd && cfg[CFG_STAT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) disp_value <= 32'h0000_0000;
    else if (meas_done && state != ST_HELD) disp_value <= meas_value;
  end

  // Configuration: written, preset or recalled from a slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RESET;
    end else if (preset_cmd) begin
      cfg <= CFG_RESET;
    end else if (recall_ok) begin
      cfg <= slot_mem[slot_no];
    end else if (wr && hit(paddr, OFF_CFG)) begin
      cfg <= pwdata[CFG_W-1:0];
    end
  end

  // save slots; erased by every reset, and again by power-up init with key held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_valid <= '0;
      init_cnt   <= 2'h0;
      for (int i = 0; i < SLOTS; i++) slot_mem[i] <= CFG_RESET;
    end else begin
      // Key is only valid once it has crossed both sync stages
      if (init_cnt != 2'h3) init_cnt <= init_cnt + 2'h1;
      if (init_cnt == 2'h2 && pin_s2[3]) begin
        slot_valid <= '0;
      end else if (wr && hit(paddr, OFF_SLOT) && pwdata[SLOT_SAVE]
                   && slot_no < 4'(SLOTS)) begin
        slot_mem[slot_no]   <= cfg;
        slot_valid[slot_no] <= 1'b1;
      end
    end
  end

  // bus address, out-of-range writes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gpib_addr <= 5'h00;
    else if (wr && hit(paddr, OFF_GPIB) && pwdata[31:0] <= 32'(GPIB_ADDR_MAX))
      gpib_addr <= pwdata[4:0];
  end

  // reference selection; detector code names 1/2/5/10 MHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sel_ext <= 1'b0;
      ref_freq    <= 2'h0;
    end else begin
      ref_sel_ext <= cfg[CFG_REFAUTO] && pin_s2[0];
      ref_freq    <= (cfg[CFG_REFAUTO] && pin_s2[0]) ? pin_s2[2:1] : 2'h0;
    end
  end

  // judgment latched until the next result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) judge_q <= 1'b0;
    else if (judge_valid) judge_q <= judge_pass;
  end

  chc_aux_pulse u_end (
    .pclk    (pclk),
    .presetn (presetn),
    .trig    (meas_done),
    .pulse_n (end_n)
  );

  chc_aux_pulse u_rest (
    .pclk    (pclk),
    .presetn (presetn),
    .trig    (restart_cmd),
    .pulse_n (rest_n)
  );

  // aux source mux; unused code behaves as none
  always_comb begin
    unique case (aux_sel(cfg))
      // forced low when limit checking disabled
      AUX_GO:   next_aux = cfg[CFG_TEMP] && judge_q;
      AUX_END:  next_aux = end_n;
      AUX_LVL:  next_aux = cfg[CFG_BURST] ? burst_det : 1'b1;
      AUX_GATE: next_aux = gate_open;
      AUX_REST: next_aux = rest_n;
      AUX_ACQ:  next_aux = !acq_busy;
      default:  next_aux = 1'b1;
    endcase
  end

  // Registered so the connector never sees mux glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) aux_out <= 1'b1;
    else aux_out <= next_aux;
  end

  // off still lights setup screens at the lowest level
  assign lcd_level = (cfg[CFG_BRT_LSB +: 3] == BRT_OFF && setup_screen)
                     ? BRT_25 : cfg[CFG_BRT_LSB +: 3];

  // Fast sample counts and offset for host-side arithmetic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_m      <= 32'h0000_0000;
      fast_t      <= 32'h0000_0000;
      offset_freq <= 32'h0000_0000;
      store_idx   <= 7'h00;
    end else begin
      if (fast_valid) begin
        fast_m <= fast_interval;
        fast_t <= fast_ref;
      end
      if (wr && hit(paddr, OFF_OFFSET)) offset_freq <= pwdata;
      if (wr && hit(paddr, OFF_STORE_IDX)) store_idx <= pwdata[6:0];
    end
  end

  assign sif.start  = wr && hit(paddr, OFF_CTRL) && pwdata[CTL_ST_GO];
  assign sif.stop   = wr && hit(paddr, OFF_CTRL) && pwdata[CTL_ST_STOP];
  assign sif.push   = meas_done;
  assign sif.wdata  = meas_value;
  assign sif.rd_idx = store_idx;

  chc_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  // execution error flag: set wins over the status-read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) store_err <= 1'b0;
    else if (rd_setup && hit(paddr, OFF_STORE_DAT)
             && (sif.running || !sif.full)) store_err <= 1'b1;
    else if (rd_setup && hit(paddr, OFF_STATUS)) store_err <= 1'b0;
  end

  // Read mux, captured in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      OFF_CFG:       next_rdata = 32'(cfg);
      OFF_STATUS:    next_rdata = {12'h000, slot_valid, store_err,
                                   judge_q, sif.full, sif.running,
                                   ref_freq, ref_sel_ext, state};
      OFF_GPIB:      next_rdata = 32'(gpib_addr);
      OFF_STORE_IDX: next_rdata = 32'(store_idx);
      // zero hertz unless stopped with 100 stored
      OFF_STORE_DAT: next_rdata = (sif.running || !sif.full)
                                  ? 32'h0000_0000 : sif.rd_data;
      OFF_FAST_M:    next_rdata = fast_m;
      OFF_FAST_T:    next_rdata = fast_t;
      OFF_OFFSET:    next_rdata = offset_freq;
      OFF_DISP:      next_rdata = disp_value;
      default:       next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= next_rdata;
  end

  // Checks
  property p_held_stops;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_RUN && hold_cmd) |=> !meas_enable && hold_led;
  endproperty
  a_held_stops: assert property (p_held_stops) else $error("hold ignored");
  property p_single_back;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_SINGLE && !cfg[CFG_STAT] && meas_done && !hold_cmd)
      |=> state == ST_HELD;
  endproperty
  a_single_back: assert property (p_single_back) else $error("no re-hold");
  property p_stat_back;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_SINGLE && cfg[CFG_STAT] && stat_done && !hold_cmd)
      |=> state == ST_HELD;
  endproperty
  a_stat_back: assert property (p_stat_back) else $error("stat re-hold");
  property p_resume;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_HELD && hold_cmd) |=> !hold_led ##1 meas_enable;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (restart_cmd && cfg[CFG_STAT]) |=> stat_clear && meas_restart;
  endproperty
  a_clear: assert property (p_clear) else $error("no sample clear");
  property p_addr;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, OFF_GPIB) && pwdata > 32'(GPIB_ADDR_MAX))
      |=> $stable(gpib_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address taken");
  property p_off_high;
    @(posedge pclk) disable iff (!presetn)
    (aux_sel(cfg) == AUX_OFF) [*2] |-> aux_out;
  endproperty
  a_off_high: assert property (p_off_high) else $error("aux off not high");
  property p_store_zero;
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && hit(paddr, OFF_STORE_DAT) && sif.running)
      |=> prdata == 32'h0000_0000;
  endproperty
  a_store_zero: assert property (p_store_zero) else $error("read not zero");
  c_single: cover property (@(posedge pclk) state == ST_SINGLE ##1
                            state == ST_HELD);
  c_full: cover property (@(posedge pclk) sif.full && !sif.running);
  c_rest: cover property (@(posedge pclk) !rest_n && aux_out == 1'b0);
endmodule // chc_ctrl

//--- logic/chc_pkg.sv
// Constants, register map and state codes for the counter hold/aux/store
// control block. Assumes a 10 MHz APB clock.
package chc_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_CFG       = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_GPIB      = 8'h0C;
  localparam logic [7:0] OFF_SLOT      = 8'h10;
  localparam logic [7:0] OFF_STORE_IDX = 8'h14;
  localparam logic [7:0] OFF_STORE_DAT = 8'h18;
  localparam logic [7:0] OFF_FAST_M    = 8'h1C;
  localparam logic [7:0] OFF_FAST_T    = 8'h20;
  localparam logic [7:0] OFF_OFFSET    = 8'h24;
  localparam logic [7:0] OFF_DISP      = 8'h28;
  // Command bits in the control register (write one to act)
  localparam int CTL_HOLD    = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_PRESET  = 2;
  localparam int CTL_ST_GO   = 3;
  localparam int CTL_ST_STOP = 4;
  // Configuration word layout
  localparam int CFG_W       = 10;
  localparam int CFG_STAT    = 0;
  localparam int CFG_TEMP    = 1;
  localparam int CFG_BURST   = 2;
  localparam int CFG_REFAUTO = 3;
  localparam int CFG_AUX_LSB = 4;
  localparam int CFG_BRT_LSB = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h008;
  // Slot command layout
  localparam int SLOT_SAVE   = 4;
  localparam int SLOT_RECALL = 5;
  localparam int SLOTS       = 10;
  localparam logic [4:0] GPIB_ADDR_MAX = 5'h1E;
  localparam int STORE_DEPTH = 100;
  // Aux source codes
  localparam logic [2:0] AUX_OFF  = 3'h0;
  localparam logic [2:0] AUX_GO   = 3'h1;
  localparam logic [2:0] AUX_END  = 3'h2;
  localparam logic [2:0] AUX_LVL  = 3'h3;
  localparam logic [2:0] AUX_GATE = 3'h4;
  localparam logic [2:0] AUX_REST = 3'h5;
  localparam logic [2:0] AUX_ACQ  = 3'h6;
  // Brightness codes: off, 25, 50, 75, 100 percent
  localparam logic [2:0] BRT_OFF  = 3'h0;
  localparam logic [2:0] BRT_25   = 3'h1;
  // Aux pulse timing, least time rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int AUX_PULSE_NS  = 1000;
  localparam logic [3:0] AUX_PULSE_CYC =
    4'((AUX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Measurement loop states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_HELD   = 3'b010,
    ST_SINGLE = 3'b100
  } chc_hold_e;
endpackage

//--- logic/chc_store_if.sv
// Link between the controller and the rolling measurement store.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ns
interface chc_store_if;
  logic        start;
  logic        stop;
  logic        push;
  logic [31:0] wdata;
  logic [6:0]  rd_idx;
  logic [31:0] rd_data;
  logic        full;
  logic        running;
  modport ctrl  (output start, stop, push, wdata, rd_idx,
                 input rd_data, full, running);
  modport store (input start, stop, push, wdata, rd_idx,
                 output rd_data, full, running);
endinterface

//--- logic/chc_aux_pulse.sv
// Fixed-width active-low pulse generator for the aux connector.
// Assumes trig is a one-cycle pulse on pclk.
`timescale 1ns/1ns
module chc_aux_pulse
  import chc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Trigger and pulse
  input  wire logic trig,
  output logic      pulse_n
);
  logic [3:0] cnt;
  logic [3:0] low_run;

  // cycle counted width; retrigger while active is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
    end else if (trig && cnt == 4'h0) begin
      cnt <= AUX_PULSE_CYC;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end

  assign pulse_n = (cnt == 4'h0);

  // low cycles counted; a long pulse is too wide to unroll in a check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_run <= 4'h0;
    end else if (pulse_n) begin
      low_run <= 4'h0;
    end else begin
      low_run <= low_run + 4'h1;
    end
  end

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (trig && pulse_n) |=> !pulse_n;
  endproperty
  a_start: assert property (p_start) else $error("aux pulse missing");
  property p_width;
    @(posedge pclk) disable iff (!presetn)
    $rose(pulse_n) |-> low_run == AUX_PULSE_CYC;
  endproperty
  a_width: assert property (p_width) else $error("aux pulse width");
endmodule // chc_aux_pulse

//--- logic/chc_store.sv
// Rolling store of the latest measurements in flip-flops.
// Assumes push is a one-cycle pulse per finished measurement.
`timescale 1ns/1ns
module chc_store
  import chc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Controller side
  chc_store_if.store sif
);
  logic [31:0] mem [STORE_DEPTH];
  logic [6:0]  wr_ptr;
  logic [6:0]  count;
  logic [7:0]  pos;

  // write pointer wraps, oldest entry is overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 7'h00;
      count  <= 7'h00;
      sif.running <= 1'b0;
    end else if (sif.start) begin
      wr_ptr <= 7'h00;
      count  <= 7'h00;
      sif.running <= 1'b1;
    end else if (sif.stop) begin
      sif.running <= 1'b0;
    end else if (sif.running && sif.push) begin
      wr_ptr <= (wr_ptr == 7'(STORE_DEPTH - 1)) ? 7'h00 : wr_ptr + 7'h1;
      if (count != 7'(STORE_DEPTH)) count <= count + 7'h1;
    end
  end

  // Entry storage, no reset needed on data
  always_ff @(posedge pclk) begin
    if (sif.running && sif.push && !sif.start && !sif.stop)
      mem[wr_ptr] <= sif.wdata;
  end

  // Read index counts from wr_ptr, which is the oldest valid entry once the store is full
  always_comb begin
    pos = {1'b0, wr_ptr} + {1'b0, sif.rd_idx};
    if (pos >= 8'(STORE_DEPTH)) pos = pos - 8'(STORE_DEPTH);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sif.rd_data <= 32'h0000_0000;
    else if (sif.rd_idx >= 7'(STORE_DEPTH)) sif.rd_data <= 32'h0000_0000;
    else sif.rd_data <= mem[pos[6:0]];
  end

  assign sif.full = (count == 7'(STORE_DEPTH));
endmodule // chc_store

//--- tb/chc_aux_rx.sv
// Aux connector receiver model: measures widths of low pulses.
// Assumes the aux line is sampled on rising edges of pclk.
`timescale 1ns/1ns
module chc_aux_rx (
  // Clock and line
  input  wire logic pclk,
  input  wire logic aux_out,
  // Measured pulses
  output int        width,
  output int        pulses
);
  int run = 0;

  // Width is taken when the line returns high, so a stuck low never counts
  always @(posedge pclk) begin
    if (aux_out === 1'b0) begin
      run <= run + 1;
    end else if (run > 0) begin
      width  <= run;
      pulses <= pulses + 1;
      run    <= 0;
    end
  end
endmodule // chc_aux_rx

//--- tb/chc_ctrl_tb.sv
// Self-checking bench for chc_ctrl: APB host tasks, core and pin stimulus.
// Assumes a zero-wait APB slave and the aux receiver model beside it.
`timescale 1ns/1ns
module chc_ctrl_tb;
  import chc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, meas_value = '0, fi = '0, fr = '0, prdata, rd;
  logic        meas_done = 0, stat_done = 0, judge_valid = 0;
  logic        judge_pass = 0, gate_open = 0, burst_det = 0, acq_busy = 0;
  logic        fast_valid = 0, setup_scr = 0, ext_p = 0, ikey = 0;
  logic [1:0]  ext_c = '0, ref_freq;
  logic        pready, pslverr, slv, meas_enable, meas_restart, stat_clear;
  logic        hold_led, ref_sel_ext, aux_out;
  logic [2:0]  lcd_level;
  logic [4:0]  gpib_addr;
  int          err_count = 0, samples_checked = 0, n_rs = 0, n_clr = 0;
  int          width, pulses, p0;

  // Free-running 10 MHz clock
  always #50 pclk = ~pclk;

  // Count one-cycle pulses so none is missed between checks
  always @(posedge pclk) begin
    n_rs  <= n_rs + meas_restart;
    n_clr <= n_clr + stat_clear;
  end

  chc_ctrl chc_ctrl_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .meas_done, .meas_value, .stat_done, .judge_valid,
    .judge_pass, .gate_open, .burst_det, .acq_busy, .fast_valid,
    .fast_interval(fi), .fast_ref(fr), .setup_screen(setup_scr),
    .meas_enable, .meas_restart, .stat_clear, .ext_ref_present(ext_p),
    .ext_ref_code(ext_c), .init_key(ikey), .hold_led, .ref_sel_ext,
    .ref_freq, .aux_out, .lcd_level, .gpib_addr
  );
  chc_aux_rx chc_aux_rx_i (.pclk, .aux_out, .width, .pulses);

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      report_and_stop;
    end
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Let register and synchroniser stages land, then sample off the edge
  task automatic st;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic state(input logic [2:0] e);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd[2:0], e);
  endtask

  task automatic done(input logic [31:0] v);
    @(posedge pclk);
    meas_done  <= 1'b1;
    meas_value <= v;
    @(posedge pclk);
    meas_done  <= 1'b0;
  endtask

  task automatic sdone;
    @(posedge pclk) stat_done <= 1'b1;
    @(posedge pclk) stat_done <= 1'b0;
  endtask

  // Judgment pass level flips after the strobe to expose a missing latch
  task automatic jv(input logic p);
    @(posedge pclk);
    judge_valid <= 1'b1;
    judge_pass  <= p;
    @(posedge pclk);
    judge_valid <= 1'b0;
    judge_pass  <= ~p;
  endtask

  task automatic auxchk(input logic [6:0] c, input logic e);
    wr(OFF_CFG, {25'h0, c});
    st;
    chk(aux_out, e);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_CFG, CFG_RESET);
    chk(aux_out, 1'b1); // idle high
    ext_p <= 1'b1;
    ext_c <= 2'h2;
    st;
    chk({ref_sel_ext, ref_freq}, 3'h6); // auto picks 5 MHz
    wr(OFF_CFG, 32'h0000_0000);
    st;
    chk(ref_sel_ext, 1'b0); // internal only
    @(posedge pclk) setup_scr <= 1'b1;
    st;
    chk(lcd_level, 3'h1); // setup at 25
    @(posedge pclk) setup_scr <= 1'b0;
    for (int b = 0; b < 5; b++) begin
      wr(OFF_CFG, b << 7);
      st;
      chk(lcd_level, b); // level codes
    end
    $display("test ref and display done");
    wr(OFF_GPIB, GPIB_ADDR_MAX);
    wr(OFF_GPIB, GPIB_ADDR_MAX + 1);
    st;
    chk(gpib_addr, GPIB_ADDR_MAX); // 31 refused
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(slv, 1'b1);
    chk(rd, 32'h0000_0000);
    wr(OFF_SLOT, (1 << SLOT_SAVE) | 3);
    wr(OFF_SLOT, (1 << SLOT_SAVE) | 10);
    wr(OFF_CTRL, 1 << CTL_PRESET);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd[19:10], 10'h008); // slot kept
    rdc(OFF_CFG, CFG_RESET);
    wr(OFF_SLOT, (1 << SLOT_RECALL) | 3);
    rdc(OFF_CFG, 32'h0000_0200); // slot recalled
    $display("test bus and slots done");
    wr(OFF_CTRL, 1 << CTL_HOLD);
    st;
    chk({hold_led, meas_enable}, 2'b10); // held
    state(ST_HELD); // held
    wr(OFF_CTRL, 1 << CTL_RESTART);
    state(ST_SINGLE); // one shot
    chk(n_rs, 1); // restart issued
    done(32'h0000_0001);
    state(ST_HELD); // back to hold
    wr(OFF_CFG, CFG_RESET | 1);
    state(ST_SINGLE); // setting change
    done(32'h0000_0002);
    state(ST_SINGLE); // waits for statistic
    sdone;
    state(ST_HELD); // back to hold
    done(32'h0000_0009);
    rdc(OFF_DISP, 32'h0000_0002); // last value kept
    wr(OFF_CTRL, 1 << CTL_RESTART);
    st;
    chk(n_clr, 1); // sample count cleared
    sdone;
    wr(OFF_CTRL, 1 << CTL_HOLD);
    st;
    chk({hold_led, meas_enable}, 2'b01); // resumed
    state(ST_RUN); // resumed
    $display("test hold done");
    wr(OFF_CFG, 32'h0000_001A);
    jv(1'b0);
    st;
    chk(aux_out, 1'b0); // outside
    jv(1'b1);
    st;
    chk(aux_out, 1'b1); // inside
    auxchk({AUX_GO, 4'h8}, 1'b0); // disabled low
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk) gate_open <= v[0];
      burst_det <= v[0];
      acq_busy  <= v[0];
      auxchk({AUX_GATE, 4'h8}, v[0]); // gate mirror
      auxchk({AUX_LVL, 4'hC}, v[0]); // burst follows
      auxchk({AUX_LVL, 4'h8}, 1'b1); // cw high
      auxchk({AUX_ACQ, 4'h8}, ~v[0]); // acquire low
      auxchk({3'h7, 4'h8}, 1'b1); // unused code high
      auxchk({AUX_OFF, 4'h8}, 1'b1); // off high
    end
    p0 = pulses;
    wr(OFF_CFG, {AUX_END, 4'h8});
    done(32'h0000_0003);
    repeat (16) @(posedge pclk);
    chk(width, 10); // one microsecond
    wr(OFF_CFG, {AUX_REST, 4'h8});
    wr(OFF_CTRL, 1 << CTL_RESTART);
    repeat (16) @(posedge pclk);
    chk(width, 10); // one microsecond
    chk(pulses - p0, 2); // one pulse each
    $display("test aux done");
    fi <= 32'h0000_0005;
    fr <= 32'h0000_0007;
    @(posedge pclk) fast_valid <= 1'b1;
    @(posedge pclk) fast_valid <= 1'b0;
    rdc(OFF_FAST_M, 32'h0000_0005); // interval count
    rdc(OFF_FAST_T, 32'h0000_0007); // reference count
    wr(OFF_OFFSET, 32'h0000_1234);
    rdc(OFF_OFFSET, 32'h0000_1234); // offset kept
    wr(OFF_CTRL, 1 << CTL_ST_GO);
    for (int i = 1; i < 6; i++) done(i);
    wr(OFF_CTRL, 1 << CTL_ST_STOP);
    rdc(OFF_STORE_DAT, 32'h0000_0000); // stopped short
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd[9], 1'b1); // error flagged
    wr(OFF_CTRL, 1 << CTL_ST_GO);
    for (int i = 1; i < 102; i++) done(i);
    rdc(OFF_STORE_DAT, 32'h0000_0000); // still running
    wr(OFF_CTRL, 1 << CTL_ST_STOP);
    wr(OFF_STORE_IDX, 32'h0000_0000);
    rdc(OFF_STORE_DAT, 32'h0000_0002); // oldest dropped
    wr(OFF_STORE_IDX, STORE_DEPTH - 1);
    rdc(OFF_STORE_DAT, 32'h0000_0065); // newest kept
    $display("test store done");
    ikey    <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    st;
    chk({hold_led, aux_out, gpib_addr}, 7'h20); // idle after reset
    state(ST_RUN); // not held after reset
    chk(rd[19:10], 10'h000); // slots erased
    $display("test reset done");
    report_and_stop;
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (50000) @(posedge pclk);
    err_count++;
    report_and_stop;
  end
endmodule // chc_ctrl_tb
